// File: logic/ssd_data_regs.sv
// serial port data register path with apb register file
// Function
// R1: fifo on: written transmit word goes into the transmit fifo
// R2: fifo off: transmit register goes straight toward the shift register
// R3: 8-bit mode sends upper byte only, bit 8 is the lsb
// R4: transmit data left justified, bit 15 msb; 16-bit mode sends all bits
// R5: fifo off: received word goes straight into receive data register
// R6: fifo on: received word is pushed into the receive fifo
// R7: 16-bit mode shows all sixteen received bits
// R8: 8-bit mode copies received byte into both halves of receive data
// R9: six 16-bit registers decoded four bytes apart, receive 00h, transmit 04h; code also decodes a seventh, the path register at 18h
// R10: word length field of control_status_one picks 16-bit or 8-bit words
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
module ssd_data_regs (
    input  wire logic        sys_clk,        // 200 MHz clock
    input  wire logic        rst,            // sync reset, active high
    input  wire logic        ce,             // clock enable, freezes state
    input  wire logic        psel,           // apb select
    input  wire logic        penable,        // apb access phase
    input  wire logic        pwrite,         // apb direction
    input  wire logic [7:0]  paddr,          // apb byte address
    input  wire logic [31:0] pwdata,         // apb write data
    output logic      [31:0] prdata,         // apb read data
    output logic             pready,         // apb transfer done
    output logic             pslverr,        // apb unmapped address
    output logic      [15:0] tx_word,        // word to shift register
    output logic             tx_valid,       // tx_word valid
    input  wire logic        tx_ready,       // shift register takes word
    input  wire logic [15:0] rx_word,        // word from shift register
    input  wire logic        rx_valid,       // rx_word valid
    output logic             rx_ready,       // space for a received word
    output logic      [15:0] ctrl_one,       // control_status_one contents
    output logic      [15:0] clk_divider,    // serial_clock_divider contents
    output logic      [15:0] dma_control     // dma_interface_control contents
);
    ssd_pkg::ssd_state_t state;
    logic [15:0] receive_data;
    logic [15:0] csr_two_cfg;
    logic        fifo_enable;
    logic        rx_overflow;
    logic [15:0] tx_hold;
    logic        tx_hold_v;
    logic        word_is_8bit;
    logic        access;
    logic        hit_rx;
    logic        hit_tx;
    logic        hit_csr1;
    logic        hit_csr2;
    logic        hit_clk;
    logic        hit_dma;
    logic        hit_path;
    logic        mapped;
    logic        tx_space;
    logic        go;
    logic        do_write;
    logic        do_read;
    logic        flush;
    logic [15:0] tx_fmt;
    logic [15:0] next_rdata;
    logic [15:0] csr_two_view;
    // transmit fifo and buffer wiring
    logic [15:0] txf_head;
    logic        txf_full;
    logic        txf_empty;
    logic        txf_push;
    logic        txf_pop;
    logic [15:0] txb_in;
    logic        txb_in_valid;
    logic        txb_in_ready;
    logic        tx_take;
    // receive fifo and buffer wiring
    logic [15:0] rxb_word;
    logic        rxb_valid;
    logic        rxb_ready;
    logic [15:0] rx_fmt;
    logic [15:0] rxf_head;
    logic        rxf_full;
    logic        rxf_empty;
    logic        rxf_push;
    logic        rxf_pop;
    logic        rx_arrive;

    // word size select from the length field
    assign word_is_8bit = (ctrl_one[ssd_pkg::LEN_LSB +: ssd_pkg::LEN_W]
                           == ssd_pkg::LEN_8BIT);                    // [R10]

    // address decode, one aligned word per register
    assign hit_rx   = (paddr == ssd_pkg::REG_RX_DATA);              // [R9]
    assign hit_tx   = (paddr == ssd_pkg::REG_TX_DATA);              // [R9]
    assign hit_csr1 = (paddr == ssd_pkg::REG_CSR_ONE);              // [R9]
    assign hit_csr2 = (paddr == ssd_pkg::REG_CSR_TWO);              // [R9]
    assign hit_clk  = (paddr == ssd_pkg::REG_CLK_DIV);              // [R9]
    assign hit_dma  = (paddr == ssd_pkg::REG_DMA_CTL);              // [R9]
    assign hit_path = (paddr == ssd_pkg::REG_PATH);
    assign mapped   = hit_rx || hit_tx || hit_csr1 || hit_csr2
                      || hit_clk || hit_dma || hit_path;

    // transfer control: a transmit write waits for a free slot
    assign access   = psel && penable && (state == ssd_pkg::SSD_IDLE);
    assign tx_space = fifo_enable ? !txf_full : !tx_hold_v;
    assign go       = access && !(pwrite && hit_tx && !tx_space);
    assign do_write = go && pwrite && mapped;
    assign do_read  = go && !pwrite && mapped;
    assign flush    = do_write && hit_csr2 && pwdata[ssd_pkg::BIT_DFIFO];

    // left-justified transmit word, low byte dropped in 8-bit mode
    assign tx_fmt = word_is_8bit ?
                    {pwdata[15:8], ssd_pkg::BYTE_W'(0)} :           // [R3]
                    pwdata[15:0];                                   // [R4]

    // received word, byte copied to both halves in 8-bit mode
    assign rx_fmt = word_is_8bit ?
                    {rxb_word[7:0], rxb_word[7:0]} :                // [R8]
                    rxb_word;                                       // [R7]

    // live status view of control_status_two
    always_comb begin
        csr_two_view = csr_two_cfg & ssd_pkg::CSR2_WMASK;
        csr_two_view[ssd_pkg::BIT_TFNE] = !txf_full;
        csr_two_view[ssd_pkg::BIT_TFF]  = txf_full;
        csr_two_view[ssd_pkg::BIT_TEMP] = txf_empty;
        csr_two_view[ssd_pkg::BIT_ROFL] = rx_overflow;
        csr_two_view[ssd_pkg::BIT_RFF]  = rxf_full;
        csr_two_view[ssd_pkg::BIT_RFNE] = !rxf_empty;
    end

    // read data mux, receive read returns fifo head when fifo is on and not empty
    always_comb begin
        next_rdata = 16'h0000;
        case (1'b1)
            hit_rx: begin
                if (fifo_enable && !rxf_empty) begin
                    next_rdata = rxf_head;                          // [R6]
                end else begin
                    next_rdata = receive_data;                      // [R5]
                end
            end
            hit_csr1: next_rdata = ctrl_one;
            hit_csr2: next_rdata = csr_two_view;
            hit_clk:  next_rdata = clk_divider;
            hit_dma:  next_rdata = dma_control;
            hit_path: next_rdata = {15'h0000, fifo_enable};
            default:  next_rdata = 16'h0000;
        endcase
    end

    // apb slave handshake, answer one cycle into the access phase
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state   <= ssd_pkg::SSD_IDLE;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            case (state)
                ssd_pkg::SSD_IDLE: begin
                    if (go) begin
                        state   <= ssd_pkg::SSD_ACK;
                        pready  <= 1'b1;
                        pslverr <= !mapped;
                        prdata  <= do_read ? {16'h0000, next_rdata} : 32'h0000_0000;
                    end
                end
                ssd_pkg::SSD_ACK: begin
                    state   <= ssd_pkg::SSD_IDLE;
                    pready  <= 1'b0;
                    pslverr <= 1'b0;
                end
                default: begin
                    state  <= ssd_pkg::SSD_IDLE;
                    pready <= 1'b0;
                end
            endcase
        end
    end

    // configuration registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_one    <= ssd_pkg::CSR1_RESET;
            csr_two_cfg <= ssd_pkg::CSR2_RESET;
            clk_divider <= ssd_pkg::CLK_RESET;
            dma_control <= ssd_pkg::DMA_RESET;
            fifo_enable <= 1'b0;
        end else if (ce && do_write) begin
            if (hit_csr1) begin
                ctrl_one <= pwdata[15:0] & ssd_pkg::CSR1_WMASK;     // [R10]
            end
            if (hit_csr2) begin
                csr_two_cfg <= pwdata[15:0] & ssd_pkg::CSR2_WMASK;
            end
            if (hit_clk) begin
                clk_divider <= pwdata[15:0] & ssd_pkg::CLK_WMASK;
            end
            if (hit_dma) begin
                dma_control <= pwdata[15:0] & ssd_pkg::DMA_WMASK;
            end
            if (hit_path) begin
                fifo_enable <= pwdata[ssd_pkg::BIT_FIFO_EN];
            end
        end
    end

    // transmit routing: fifo when enabled, else direct holding slot
    assign txf_push     = do_write && hit_tx && fifo_enable;        // [R1]
    assign txb_in       = fifo_enable ? txf_head : tx_hold;
    assign txb_in_valid = fifo_enable ? !txf_empty : tx_hold_v;
    assign tx_take      = txb_in_valid && txb_in_ready;
    assign txf_pop      = tx_take && fifo_enable;

    // direct transmit slot, loaded by a write, freed toward the shifter
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_hold   <= 16'h0000;
            tx_hold_v <= 1'b0;
        end else if (ce) begin
            if (do_write && hit_tx && !fifo_enable) begin
                tx_hold   <= tx_fmt;                                // [R2]
                tx_hold_v <= 1'b1;                                  // [R2]
            end else if (tx_take && !fifo_enable) begin
                tx_hold_v <= 1'b0;
            end
        end
    end

    ssd_fifo #(
        .W     (ssd_pkg::DATA_W),
        .DEPTH (ssd_pkg::FIFO_DEPTH),
        .AW    (ssd_pkg::FIFO_AW)
    ) u_tx_fifo (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ce      (ce),
        .flush   (flush),
        .push    (txf_push),
        .wdata   (tx_fmt),
        .pop     (txf_pop),
        .rdata   (txf_head),
        .full    (txf_full),
        .empty   (txf_empty)
    );

    ssd_buf2 #(
        .W (ssd_pkg::DATA_W)
    ) u_tx_buf (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .ce        (ce),
        .in_data   (txb_in),
        .in_valid  (txb_in_valid),
        .in_ready  (txb_in_ready),
        .out_data  (tx_word),
        .out_valid (tx_valid),
        .out_ready (tx_ready)
    );

    // receive side: buffer absorbs stalls while the fifo is full
    ssd_buf2 #(
        .W (ssd_pkg::DATA_W)
    ) u_rx_buf (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .ce        (ce),
        .in_data   (rx_word),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .out_data  (rxb_word),
        .out_valid (rxb_valid),
        .out_ready (rxb_ready)
    );

    assign rxb_ready = fifo_enable ? !rxf_full : 1'b1;
    assign rx_arrive = rxb_valid && rxb_ready;
    assign rxf_push  = rx_arrive && fifo_enable;                    // [R6]
    assign rxf_pop   = do_read && hit_rx && fifo_enable && !rxf_empty;

    ssd_fifo #(
        .W     (ssd_pkg::DATA_W),
        .DEPTH (ssd_pkg::FIFO_DEPTH),
        .AW    (ssd_pkg::FIFO_AW)
    ) u_rx_fifo (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ce      (ce),
        .flush   (flush),
        .push    (rxf_push),
        .wdata   (rx_fmt),
        .pop     (rxf_pop),
        .rdata   (rxf_head),
        .full    (rxf_full),
        .empty   (rxf_empty)
    );

    // receive data register: direct load, or last word popped from fifo
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            receive_data <= ssd_pkg::RX_RESET;
        end else if (ce) begin
            if (rx_arrive && !fifo_enable) begin
                receive_data <= rx_fmt;                             // [R5]
            end else if (rxf_pop) begin
                receive_data <= rxf_head;                           // [R6]
            end
        end
    end

    // overflow: a word offered while no space, set wins over clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_overflow <= 1'b0;
        end else if (ce) begin
            if (rx_valid && !rx_ready) begin
                rx_overflow <= 1'b1;
            end else if (do_write && hit_csr2 && pwdata[ssd_pkg::BIT_ROFL]) begin
                rx_overflow <= 1'b0;
            end
        end
    end
endmodule

// File: logic/ssd_pkg.sv
// shared constants for the serial port data register path
package ssd_pkg;
    // bus and data widths
    localparam int APB_AW     = 8;
    localparam int DATA_W     = 16;
    localparam int BYTE_W     = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_AW    = 3;
    // register byte offsets
    localparam logic [7:0] REG_RX_DATA = 8'h00;
    localparam logic [7:0] REG_TX_DATA = 8'h04;
    localparam logic [7:0] REG_CSR_ONE = 8'h08;
    localparam logic [7:0] REG_CSR_TWO = 8'h0C;
    localparam logic [7:0] REG_CLK_DIV = 8'h10;
    localparam logic [7:0] REG_DMA_CTL = 8'h14;
    localparam logic [7:0] REG_PATH    = 8'h18;
    // reset values
    localparam logic [15:0] RX_RESET   = 16'h0000;
    localparam logic [15:0] CSR1_RESET = 16'h0000;
    localparam logic [15:0] CSR2_RESET = 16'h0000;
    localparam logic [15:0] CLK_RESET  = 16'h0006;
    localparam logic [15:0] DMA_RESET  = 16'h0000;
    // writable bit masks, reserved bits read as zero
    localparam logic [15:0] CSR1_WMASK = 16'hFF1F;
    localparam logic [15:0] CSR2_WMASK = 16'hFC00;
    localparam logic [15:0] CLK_WMASK  = 16'h00FF;
    localparam logic [15:0] DMA_WMASK  = 16'h00FF;
    // word length field in control_status_one
    localparam int         LEN_LSB  = 10;
    localparam int         LEN_W    = 2;
    localparam logic [1:0] LEN_8BIT = 2'h0;
    // status and command bits in control_status_two
    localparam int BIT_TFNE  = 9;
    localparam int BIT_TFF   = 8;
    localparam int BIT_TEMP  = 6;
    localparam int BIT_ROFL  = 5;
    localparam int BIT_RFF   = 4;
    localparam int BIT_RFNE  = 3;
    localparam int BIT_DFIFO = 0;
    // fifo enable bit in the path register
    localparam int BIT_FIFO_EN = 0;
    // bus slave states, one-hot
    typedef enum logic [1:0] {
        SSD_IDLE = 2'b01,
        SSD_ACK  = 2'b10
    } ssd_state_t;
endpackage

// File: logic/ssd_fifo.sv
// small synchronous fifo with flush, used for transmit and receive
`timescale 1ns/100ps
module ssd_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    input  wire logic          sys_clk,  // clock
    input  wire logic          rst,      // sync reset
    input  wire logic          ce,       // clock enable
    input  wire logic          flush,    // drop all entries
    input  wire logic          push,     // write one word
    input  wire logic [W-1:0]  wdata,    // word written
    input  wire logic          pop,      // remove head word
    output logic      [W-1:0]  rdata,    // head word
    output logic               full,     // no space left
    output logic               empty     // nothing stored
);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;

    // flags and head word
    assign full  = (count == (AW+1)'(DEPTH));
    assign empty = (count == '0);
    assign rdata = mem[rd_ptr];

    // storage array
    always_ff @(posedge sys_clk) begin
        if (ce && push && !full) begin
            mem[wr_ptr] <= wdata;
        end
    end

    // pointers and occupancy
    always_ff @(posedge sys_clk) begin
        if (rst || (ce && flush)) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (ce) begin
            if (push && !full) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop && !empty) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push && !full) - (AW+1)'(pop && !empty);
        end
    end
endmodule

// File: logic/ssd_buf2.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module ssd_buf2 #(
    parameter int W = 16
) (
    input  wire logic         sys_clk,    // clock
    input  wire logic         rst,        // sync reset
    input  wire logic         ce,         // clock enable
    input  wire logic [W-1:0] in_data,    // word offered
    input  wire logic         in_valid,   // word offered valid
    output logic              in_ready,   // space for a word
    output logic      [W-1:0] out_data,   // head word
    output logic              out_valid,  // head word valid
    input  wire logic         out_ready   // drain side accepts
);
    logic [W-1:0] second;
    logic         second_v;
    logic         push;
    logic         pop;

    assign push     = in_valid && !second_v;
    assign pop      = out_valid && out_ready;

    // entry shuffle: head, then second slot
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_data  <= '0;
            out_valid <= 1'b0;
            second    <= '0;
            second_v  <= 1'b0;
            in_ready  <= 1'b1;
        end else if (ce) begin
            if (pop) begin
                if (second_v) begin
                    out_data <= second;
                    if (push) begin
                        second <= in_data;
                    end else begin
                        second_v <= 1'b0;
                        in_ready <= 1'b1;
                    end
                end else if (push) begin
                    out_data <= in_data;
                end else begin
                    out_valid <= 1'b0;
                end
            end else if (push) begin
                if (!out_valid) begin
                    out_data  <= in_data;
                    out_valid <= 1'b1;
                end else begin
                    second   <= in_data;
                    second_v <= 1'b1;
                    in_ready <= 1'b0;
                end
            end
        end
    end
endmodule

// File: verif/ssd_data_regs_props.sv
// concurrent checks on the data register path ports
`timescale 1ns/100ps
module ssd_data_regs_props (
    input wire logic        sys_clk,   // clock
    input wire logic        rst,       // sync reset
    input wire logic        ce,        // clock enable
    input wire logic        psel,      // apb select
    input wire logic        penable,   // apb access phase
    input wire logic        pwrite,    // apb direction
    input wire logic [7:0]  paddr,     // apb address
    input wire logic [31:0] prdata,    // apb read data
    input wire logic        pready,    // apb done
    input wire logic        pslverr,   // apb error
    input wire logic [15:0] tx_word,   // outgoing word
    input wire logic        tx_valid,  // outgoing word valid
    input wire logic        tx_ready,  // far side takes word
    input wire logic [15:0] ctrl_one   // control copy
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // access phase not yet answered
    sequence s_access;
        psel && penable && !pready && ce;
    endsequence
    sequence s_not_tx_write;
        !(pwrite && paddr == ssd_pkg::REG_TX_DATA);
    endsequence
    property p_answer;
        s_access ##0 s_not_tx_write |=> pready;
    endproperty
    property p_pulse;
        pready |=> !pready;
    endproperty
    property p_cause;
        pready |-> $past(psel && penable);
    endproperty
    property p_unmapped;
        s_access ##0 (paddr > ssd_pkg::REG_PATH) |=> pready && pslverr;
    endproperty
    property p_mapped;
        s_access ##0 (paddr <= ssd_pkg::REG_PATH && paddr[1:0] == 2'h0) |=> !pslverr;
    endproperty
    property p_tx_read;
        s_access ##0 (!pwrite && paddr == ssd_pkg::REG_TX_DATA) |=> prdata == 32'h0;
    endproperty
    property p_upper;
        pready |-> prdata[31:16] == 16'h0 && (!pslverr || prdata == 32'h0);
    endproperty
    property p_tx_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_word);
    endproperty
    property p_tx_byte;
        tx_valid && ctrl_one[11:10] == ssd_pkg::LEN_8BIT |-> tx_word[7:0] == 8'h00;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer after access");
    a_pulse: assert property (p_pulse) else $error("ready longer than a cycle");
    a_cause: assert property (p_cause) else $error("ready without access");
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    a_mapped: assert property (p_mapped) else $error("mapped address refused");
    a_tx_read: assert property (p_tx_read) else $error("transmit read not zero");
    a_upper: assert property (p_upper) else $error("read data upper half set");
    a_tx_hold: assert property (p_tx_hold) else $error("word changed while stalled");
    a_tx_byte: assert property (p_tx_byte) else $error("low byte sent in byte mode");
endmodule

// File: verif/ssd_serial_model.sv
// far side model: takes transmit words, offers received words
`timescale 1ns/100ps
module ssd_serial_model (
    input  wire logic        sys_clk,   // clock
    input  wire logic        stall,     // hold off transmit words
    input  wire logic [15:0] tx_word,   // word from the block
    input  wire logic        tx_valid,  // word from the block valid
    output logic             tx_ready,  // model takes a word
    output logic      [15:0] rx_word,   // word to the block
    output logic             rx_valid,  // word to the block valid
    input  wire logic        rx_ready   // block has space
);
    logic [15:0] got [$];
    // ready is the inverse of the stall request
    assign tx_ready = !stall;
    // collect transmit words in arrival order
    always @(posedge sys_clk) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_word);
        end
    end
    // idle receive lines at time zero
    initial begin
        rx_word = 16'h0000;
        rx_valid = 1'h0;
    end
    // offer one word until taken or the bound runs out, then scramble data
    task automatic send(input logic [15:0] w, output logic ok);
        int n;
        @(posedge sys_clk);
        rx_word <= w;
        rx_valid <= 1'h1;
        ok = 1'h0;
        for (n = 0; n < 8 && !ok; n++) begin
            @(posedge sys_clk);
            ok = rx_ready;
        end
        rx_valid <= 1'h0;
        rx_word <= ~w;
    endtask
endmodule

// File: verif/ssd_data_regs_tb.sv
// self-checking bench for the data register path
`timescale 1ns/100ps
module ssd_data_regs_tb;
    typedef struct {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] data;
        logic        err;
    } ssd_row_t;
    logic        sys_clk, rst, ce, psel, penable, pwrite, pready, pslverr;
    logic        tx_valid, tx_ready, rx_valid, rx_ready, stall;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] tx_word, rx_word, ctrl_one, clk_divider, dma_control;
    int          miscompares = 0;
    int          checked = 0;
    // reads carry expected data, writes the value written
    ssd_row_t    rows [12] = '{
        '{1'h0, 8'h00, 32'h0000, 1'h0}, '{1'h1, 8'h10, 32'h12AB, 1'h0},
        '{1'h0, 8'h10, 32'h00AB, 1'h0}, '{1'h1, 8'h14, 32'hFFFF, 1'h0},
        '{1'h0, 8'h14, 32'h00FF, 1'h0}, '{1'h1, 8'h08, 32'h0400, 1'h0},
        '{1'h0, 8'h08, 32'h0400, 1'h0}, '{1'h0, 8'h04, 32'h0000, 1'h0},
        '{1'h1, 8'h00, 32'hFFFF, 1'h0}, '{1'h0, 8'h00, 32'h0000, 1'h0},
        '{1'h1, 8'h1C, 32'h0001, 1'h1}, '{1'h0, 8'h20, 32'h0000, 1'h1}};

    ssd_data_regs u_ssd_data_regs (.sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_word(tx_word),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .ctrl_one(ctrl_one), .clk_divider(clk_divider),
        .dma_control(dma_control));
    ssd_serial_model u_ssd_serial_model (.sys_clk(sys_clk), .stall(stall),
        .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_word(rx_word),
        .rx_valid(rx_valid), .rx_ready(rx_ready));

    // 5 ns clock
    initial begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // counts and verdict, ends the run
    task automatic conclude();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // compare and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer, request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            miscompares++;
            conclude();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // wait for the next word at the far side and compare it
    task automatic expect_tx(input logic [15:0] exp);
        int n;
        for (n = 0; n < 50 && u_ssd_serial_model.got.size() == 0; n++) begin
            @(posedge sys_clk);
        end
        if (u_ssd_serial_model.got.size() == 0) begin
            miscompares++;
            conclude();
        end
        chk({16'h0, u_ssd_serial_model.got.pop_front()}, {16'h0, exp});
    endtask

    // main sequence
    initial begin
        logic [31:0] r;
        logic        e;
        logic        ok;
        int          n;
        rst = 1'h1;
        ce = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        stall = 1'h0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'h0;
        @(posedge sys_clk);
        chk({16'h0, clk_divider}, 32'h0006);
        chk({16'h0, ctrl_one}, 32'h0000);
        chk({16'h0, dma_control}, 32'h0000);
        $display("reset test done");
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].data, r, e);
            if (!rows[i].wr) begin
                chk(r, rows[i].data);
            end
            chk({31'h0, e}, {31'h0, rows[i].err});
        end
        $display("register rows done");
        apb(1'h1, 8'h04, 32'hA5C3, r, e);
        expect_tx(16'hA5C3);
        apb(1'h1, 8'h08, 32'h0000, r, e);
        apb(1'h1, 8'h04, 32'h5A77, r, e);
        expect_tx(16'h5A00);
        u_ssd_serial_model.send(16'h00C7, ok);
        apb(1'h0, 8'h00, 32'h0, r, e);
        chk(r, 32'hC7C7);
        apb(1'h1, 8'h08, 32'h0400, r, e);
        u_ssd_serial_model.send(16'h1234, ok);
        apb(1'h0, 8'h00, 32'h0, r, e);
        chk(r, 32'h1234);
        $display("direct path test done");
        apb(1'h1, 8'h18, 32'h1, r, e);
        stall <= 1'h1;
        for (int k = 1; k < 4; k++) begin
            apb(1'h1, 8'h04, 32'(k * 32'h1100), r, e);
        end
        stall <= 1'h0;
        for (int k = 1; k < 4; k++) begin
            expect_tx(16'(k * 32'h1100));
        end
        n = 0;
        ok = 1'h1;
        while (ok && n < 16) begin
            u_ssd_serial_model.send(16'(n + 32'h0F00), ok);
            if (ok) begin
                n++;
            end
        end
        chk(32'(n >= 8), 32'h1);
        for (int k = 0; k < n; k++) begin
            apb(1'h0, 8'h00, 32'h0, r, e);
            chk(r, 32'(k + 32'h0F00));
        end
        apb(1'h0, 8'h0C, 32'h0, r, e);
        chk(r & 32'h0028, 32'h0020);
        $display("fifo path test done");
        conclude();
    end
endmodule

bind ssd_data_regs ssd_data_regs_props u_ssd_data_regs_props (.sys_clk(sys_clk), .rst(rst),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_word(tx_word),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .ctrl_one(ctrl_one));
